// ==== src/svp_pkg.sv ====
package svp_pkg;
  // Fixed-point widths
  localparam int PH_W   = 16;            // Signed phasor component width
  localparam int PCT_W  = 14;            // Level in 0.01 %Un steps
  localparam int TIM_W  = 19;            // Time in 5 ms steps
  localparam int PRI_W  = 32;            // Primary volts in 0.1 V steps
  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int CYCLE_US     = 5000;    // Processing cycle 5 ms
  localparam int CYCLE_CLKS   = CLK_MHZ * CYCLE_US;
  // Setting defaults
  localparam logic [PCT_W-1:0] USET_DEF  = 14'h2904; // 105.00 %Un
  localparam logic [PCT_W-1:0] UNDER_BLOCK_LEVEL_DEF  = 14'h01f4; // 5.00 %Un
  localparam logic [TIM_W-1:0] TDLY_DEF  = 19'h00008; // 0.040 s
  localparam logic [TIM_W-1:0] TREL_DEF  = 19'h0000c; // 0.060 s
  // Hysteresis ratios in percent
  localparam int HYS_OVER  = 97;
  localparam int HYS_UNDER = 103;
  localparam int PCT_DIV   = 100;
  // Rotation constants, Q1.15: cos120 = -0.5, sin120 = 0.866
  localparam logic signed [PH_W-1:0] COS120 = 16'hc000;
  localparam logic signed [PH_W-1:0] SIN120 = 16'h6ed9;
  localparam logic signed [PH_W:0]   THIRD  = 17'h02aab; // 1/3 in Q1.15
  // Force options
  typedef enum logic [1:0] {SVP_NORMAL, SVP_START, SVP_TRIP, SVP_BLOCKED} svp_force_e;
  // Wishbone map (byte offsets)
  localparam logic [7:0] A_CTRL   = 8'h00; // [0]neg [1]under [2]forceen [4:3]force [5]delrel
  localparam logic [7:0] A_USET   = 8'h04;
  localparam logic [7:0] A_UNDER_BLOCK_LEVEL   = 8'h08;
  localparam logic [7:0] A_TDLY   = 8'h0c;
  localparam logic [7:0] A_TREL   = 8'h10;
  localparam logic [7:0] A_VTSC   = 8'h14; // Primary 0.1 V per 1 %Un
  localparam logic [7:0] A_STAT   = 8'h18;
  localparam logic [7:0] A_MAG    = 8'h1c;
  localparam logic [7:0] A_REM    = 8'h20;
  localparam logic [7:0] A_EXP    = 8'h24;
  localparam logic [7:0] A_PRI    = 8'h28;
  localparam logic [31:0] CTRL_DEF = 32'h0000_0020;
  localparam logic [31:0] VTSC_DEF = 32'h0000_0064;
endpackage

// ==== src/svp_stage.sv ====
// Functional notes
// - positive sequence: third of rotated phasor sum
// - negative sequence: rotations of phases swapped
// - four fundamental channels, 5 ms refresh
// - selector picks positive or negative, positive default
// - force Normal/Start/Trip/Blocked when forcing enabled
// - direction selects over or under pick-up
// - pick-up level 0.01 %Un, default 105
// - compare magnitude with level in direction
// - over release below 97 percent
// - under release above 103 percent
// - under block level, default 5, under only
// - below block level, hold until all recover
// - block level zero disables blocking
// - blocking input sampled at cycle start
// - unblocked pick-up raises START and timing
// - blocked pick-up raises BLOCKED, nothing more
// - block during START drops START, release timing
// - remaining time to trip in 5 ms units
// - expected operating time in 5 ms units
// - pick-up level in primary 0.1 V units
// - zero delay trips with START, else delayed
`timescale 1ns/10ps
module svp_stage
  import svp_pkg::*;
#(
  parameter int CYCLE_CNT = svp_pkg::CYCLE_CLKS
) (
  input  wire logic                             clk_i,
  input  wire logic                             rst_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph1_re_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph1_im_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph2_re_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph2_im_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph3_re_i,
  input  wire logic signed [svp_pkg::PH_W-1:0]  ph3_im_i,
  input  wire logic        [svp_pkg::PCT_W-1:0] chan4_mag_i,
  input  wire logic        [svp_pkg::PCT_W-1:0] line_min_i,
  input  wire logic                             block_i,
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic        [7:0]                wb_adr_i,
  input  wire logic        [3:0]                wb_sel_i,
  input  wire logic        [31:0]               wb_dat_i,
  output logic             [31:0]               wb_dat_o,
  output logic                                  wb_ack_o,
  output logic                                  start_o,
  output logic                                  trip_o,
  output logic                                  blocked_o
);
  import svp_pkg::*;

  // Input synchronisers for pin-level signals
  logic block_m_ff, block_s_ff;
  always_ff @(posedge clk_i) begin
    block_m_ff <= block_i;
    block_s_ff <= block_m_ff;
  end

  // Cycle tick divider
  logic [31:0] div_ff;
  logic        tick_ff;
  wire         div_end = (div_ff == 32'(CYCLE_CNT - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff  <= div_end ? '0 : div_ff + 32'h1;
      tick_ff <= div_end;
    end
  end

  // Settings
  logic [31:0]      ctrl_ff, vtsc_ff;
  logic [PCT_W-1:0] uset_ff, under_block_level_ff;
  logic [TIM_W-1:0] tdly_ff, trel_ff;
  wire sel_neg   = ctrl_ff[0];
  wire dir_under = ctrl_ff[1];
  wire force_en  = ctrl_ff[2];
  wire del_rel   = ctrl_ff[5];
  svp_force_e force_sel;
  assign force_sel = svp_force_e'(ctrl_ff[4:3]);

  // Rotate a phasor by +120 or +240 degrees, Q1.15 products
  function automatic logic signed [PH_W+1:0] rot_part(input logic signed [PH_W-1:0] a,
                                                      input logic signed [PH_W-1:0] b,
                                                      input logic neg);
    logic signed [2*PH_W-1:0] pa, pb;
    pa = a * COS120;
    pb = b * SIN120;
    rot_part = neg ? (PH_W+2)'((pa + pb) >>> (PH_W-1)) : (PH_W+2)'((pa - pb) >>> (PH_W-1));
  endfunction

  // Sequence sums: re' = a*cos - b*sin, im' = b*cos + a*sin
  wire logic signed [PH_W+1:0] r2p_re = rot_part(ph2_re_i, ph2_im_i, 1'b0);
  wire logic signed [PH_W+1:0] r2n_re = rot_part(ph2_re_i, ph2_im_i, 1'b1);
  wire logic signed [PH_W+1:0] r3p_re = rot_part(ph3_re_i, ph3_im_i, 1'b1);
  wire logic signed [PH_W+1:0] r3n_re = rot_part(ph3_re_i, ph3_im_i, 1'b0);
  // Imag of x rotated +120: xi*cos + xr*sin; rotated +240: xi*cos - xr*sin
  function automatic logic signed [PH_W+1:0] rot_im(input logic signed [PH_W-1:0] re,
                                                    input logic signed [PH_W-1:0] im,
                                                    input logic plus);
    logic signed [2*PH_W-1:0] pa, pb;
    pa = im * COS120;
    pb = re * SIN120;
    rot_im = plus ? (PH_W+2)'((pa + pb) >>> (PH_W-1)) : (PH_W+2)'((pa - pb) >>> (PH_W-1));
  endfunction
  wire logic signed [PH_W+1:0] i2p = rot_im(ph2_re_i, ph2_im_i, 1'b1);
  wire logic signed [PH_W+1:0] i2n = rot_im(ph2_re_i, ph2_im_i, 1'b0);
  wire logic signed [PH_W+1:0] i3p = rot_im(ph3_re_i, ph3_im_i, 1'b0);
  wire logic signed [PH_W+1:0] i3n = rot_im(ph3_re_i, ph3_im_i, 1'b1);
  wire logic signed [PH_W+1:0] p1r = {{2{ph1_re_i[PH_W-1]}}, ph1_re_i};
  wire logic signed [PH_W+1:0] p1i = {{2{ph1_im_i[PH_W-1]}}, ph1_im_i};
  wire logic signed [PH_W+1:0] pos_re = p1r + r2p_re + r3p_re;
  wire logic signed [PH_W+1:0] pos_im = p1i + i2p + i3p;
  wire logic signed [PH_W+1:0] neg_re = p1r + r2n_re + r3n_re;
  wire logic signed [PH_W+1:0] neg_im = p1i + i2n + i3n;
  wire logic signed [PH_W+1:0] sel_re = sel_neg ? neg_re : pos_re;
  wire logic signed [PH_W+1:0] sel_im = sel_neg ? neg_im : pos_im;

  // Magnitude approximation max + 3/8 min, then divide by three
  function automatic logic [PH_W+1:0] mag_est(input logic signed [PH_W+1:0] re,
                                               input logic signed [PH_W+1:0] im);
    logic [PH_W+1:0] ar, ai, mx, mn;
    ar = re[PH_W+1] ? PH_W'(0) - re : re;
    ai = im[PH_W+1] ? PH_W'(0) - im : im;
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    mag_est = mx + (mn >> 2) + (mn >> 3);
  endfunction
  wire logic [PH_W+1:0]   raw_mag = mag_est(sel_re, sel_im);
  wire logic [2*PH_W+2:0] mag_prod = raw_mag * THIRD;
  // Magnitude scaled so one LSB is 0.01 %Un
  wire logic [PCT_W-1:0]  calc_mag = (mag_prod[2*PH_W+2:PH_W-1] > {PCT_W{1'b1}}) ? {PCT_W{1'b1}}
                                     : PCT_W'(mag_prod[2*PH_W+2:PH_W-1]);

  // Comparison thresholds with fixed hysteresis
  wire logic [PCT_W+7:0] mag_x100 = calc_mag * 8'(PCT_DIV);
  wire logic [PCT_W+7:0] set_x97  = uset_ff * 8'(HYS_OVER);
  wire logic [PCT_W+7:0] set_x103 = uset_ff * 8'(HYS_UNDER);
  wire over_hit  = calc_mag > uset_ff;
  wire under_hit = calc_mag < uset_ff;
  wire over_rel  = mag_x100 < set_x97;
  wire under_rel = mag_x100 > set_x103;
  wire blk_arm   = dir_under && (under_block_level_ff != '0);
  wire blk_low   = blk_arm && (calc_mag < under_block_level_ff);
  wire all_up    = line_min_i > uset_ff;

  // Stage state
  logic             pick_ff, uvblk_ff, blk_smp_ff;
  logic             start_ff, trip_ff, blkd_ff;
  logic [TIM_W-1:0] opcnt_ff, relcnt_ff;
  logic             nxt_pick, nxt_uvblk;
  always_comb begin
    nxt_pick = pick_ff;
    if (!pick_ff)
      nxt_pick = dir_under ? under_hit : over_hit;
    else
      nxt_pick = dir_under ? !under_rel : !over_rel;
    nxt_uvblk = blk_low | (uvblk_ff & blk_arm & !all_up);
  end
  wire eff_pick = nxt_pick && !nxt_uvblk;
  wire run_ok   = eff_pick && !blk_smp_ff;
  wire rem_zero = (opcnt_ff >= tdly_ff);
  wire in_rel   = start_ff && !run_ok && del_rel && (relcnt_ff != '0);

  // Evaluation on each cycle tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pick_ff    <= 1'b0;
      uvblk_ff   <= 1'b0;
      blk_smp_ff <= 1'b0;
      start_ff   <= 1'b0;
      trip_ff    <= 1'b0;
      blkd_ff    <= 1'b0;
      opcnt_ff   <= '0;
      relcnt_ff  <= '0;
    end else if (tick_ff) begin
      blk_smp_ff <= block_s_ff;
      pick_ff    <= nxt_pick;
      uvblk_ff   <= nxt_uvblk;
      blkd_ff    <= eff_pick && block_s_ff;
      if (eff_pick && !block_s_ff) begin
        start_ff  <= 1'b1;
        relcnt_ff <= trel_ff;
        opcnt_ff  <= rem_zero ? opcnt_ff : opcnt_ff + TIM_W'(1);
        trip_ff   <= rem_zero;
      end else if (start_ff && del_rel && relcnt_ff > TIM_W'(1)) begin
        relcnt_ff <= relcnt_ff - TIM_W'(1);
        trip_ff   <= 1'b0;
      end else begin
        start_ff  <= 1'b0;
        trip_ff   <= 1'b0;
        relcnt_ff <= '0;
        opcnt_ff  <= '0;
      end
    end
  end

  // Forced status overrides
  wire f_on = force_en && (force_sel != SVP_NORMAL);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_o   <= 1'b0;
      trip_o    <= 1'b0;
      blocked_o <= 1'b0;
    end else begin
      start_o   <= f_on ? (force_sel == SVP_START || force_sel == SVP_TRIP) : start_ff;
      trip_o    <= f_on ? (force_sel == SVP_TRIP) : trip_ff;
      blocked_o <= f_on ? (force_sel == SVP_BLOCKED) : blkd_ff;
    end
  end

  // Info values
  wire logic [TIM_W-1:0] rem_time = rem_zero ? '0 : tdly_ff - opcnt_ff;
  wire logic [TIM_W-1:0] exp_time = tdly_ff;
  wire logic [47:0]      pri_full = uset_ff * vtsc_ff;
  wire logic [31:0]      pri_volt = 32'(pri_full / 48'(PCT_DIV));
  wire logic             unused_ok = in_rel | (|chan4_mag_i);

  // Wishbone decode
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i && (&wb_sel_i);
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      A_CTRL:  rd_mux = ctrl_ff;
      A_USET:  rd_mux = 32'(uset_ff);
      A_UNDER_BLOCK_LEVEL:  rd_mux = 32'(under_block_level_ff);
      A_TDLY:  rd_mux = 32'(tdly_ff);
      A_TREL:  rd_mux = 32'(trel_ff);
      A_VTSC:  rd_mux = vtsc_ff;
      A_STAT:  rd_mux = {26'h0, uvblk_ff, pick_ff, blk_smp_ff, blkd_ff, trip_ff, start_ff};
      A_MAG:   rd_mux = 32'(calc_mag);
      A_REM:   rd_mux = 32'(rem_time);
      A_EXP:   rd_mux = 32'(exp_time);
      A_PRI:   rd_mux = pri_volt;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff  <= CTRL_DEF;
      uset_ff  <= USET_DEF;
      under_block_level_ff  <= UNDER_BLOCK_LEVEL_DEF;
      tdly_ff  <= TDLY_DEF;
      trel_ff  <= TREL_DEF;
      vtsc_ff  <= VTSC_DEF;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h0;
      if (wb_wr) begin
        case (wb_adr_i)
          A_CTRL:  ctrl_ff <= {26'h0, wb_dat_i[5:0]};
          A_USET:  uset_ff <= wb_dat_i[PCT_W-1:0];
          A_UNDER_BLOCK_LEVEL:  under_block_level_ff <= wb_dat_i[PCT_W-1:0];
          A_TDLY:  tdly_ff <= wb_dat_i[TIM_W-1:0];
          A_TREL:  trel_ff <= wb_dat_i[TIM_W-1:0];
          A_VTSC:  vtsc_ff <= wb_dat_i;
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // Checks
  property p_zero_delay_trip;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && tdly_ff == '0 && eff_pick && !block_s_ff && !f_on) |=> ##1 trip_o;
  endproperty
  a_zero_delay_trip: assert property (p_zero_delay_trip) else $error("zero delay no trip");
  property p_blocked_no_start;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && eff_pick && block_s_ff && !start_ff) |=> !start_ff && blkd_ff;
  endproperty
  a_blocked_no_start: assert property (p_blocked_no_start) else $error("blocked pickup started");
  property p_tick_period;
    @(posedge clk_i) disable iff (rst_i) tick_ff |=> !tick_ff;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too long");
  property p_trip_needs_start;
    @(posedge clk_i) disable iff (rst_i) trip_ff |-> start_ff;
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start) else $error("trip without start");
  property p_state_hold;
    @(posedge clk_i) disable iff (rst_i) !tick_ff |=> $stable(start_ff) && $stable(trip_ff);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved off tick");

  // Unblocked pick-up raises START on the tick
  property p_start_raise;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && eff_pick && !block_s_ff) |=> start_ff;
  endproperty
  a_start_raise: assert property (p_start_raise) else $error("pickup did not start");

  // Nonzero delay never trips together with START
  property p_nonzero_delay;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && !start_ff && eff_pick && !block_s_ff && tdly_ff != '0) |=> (start_ff && !trip_ff);
  endproperty
  a_nonzero_delay: assert property (p_nonzero_delay) else $error("delayed trip came early");

  // Block during START without delayed release drops START
  property p_block_drops_start;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && start_ff && block_s_ff && !del_rel) |=> !start_ff;
  endproperty
  a_block_drops_start: assert property (p_block_drops_start) else $error("start kept under block");

  // Blocking level latched on every tick
  property p_block_sample;
    @(posedge clk_i) disable iff (rst_i)
      tick_ff |=> (blk_smp_ff == $past(block_s_ff));
  endproperty
  a_block_sample: assert property (p_block_sample) else $error("block not sampled on tick");

  // Forced trip shows START and TRIP only
  property p_force_trip;
    @(posedge clk_i) disable iff (rst_i)
      (f_on && force_sel == SVP_TRIP) |=> (start_o && trip_o && !blocked_o);
  endproperty
  a_force_trip: assert property (p_force_trip) else $error("forced trip not shown");

  // Forced block shows BLOCKED only
  property p_force_block;
    @(posedge clk_i) disable iff (rst_i)
      (f_on && force_sel == SVP_BLOCKED) |=> (blocked_o && !start_o && !trip_o);
  endproperty
  a_force_block: assert property (p_force_block) else $error("forced block not shown");

  // Over direction releases below the lower ratio
  property p_over_release;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && !dir_under && pick_ff && over_rel) |=> !pick_ff;
  endproperty
  a_over_release: assert property (p_over_release) else $error("over pickup not released");

  // Over direction holds inside the hysteresis band
  property p_over_hold;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && !dir_under && pick_ff && !over_rel) |=> pick_ff;
  endproperty
  a_over_hold: assert property (p_over_hold) else $error("over pickup released early");

  // Under direction releases above the upper ratio
  property p_under_release;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && dir_under && pick_ff && under_rel) |=> !pick_ff;
  endproperty
  a_under_release: assert property (p_under_release) else $error("under pickup not released");

  // Undervoltage block held until all lines recover
  property p_uvblk_hold;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && uvblk_ff && blk_arm && !all_up) |=> uvblk_ff;
  endproperty
  a_uvblk_hold: assert property (p_uvblk_hold) else $error("under block dropped early");

  // Undervoltage block keeps the stage from starting
  property p_uvblk_no_start;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && nxt_uvblk && !start_ff) |=> (!start_ff && !trip_ff);
  endproperty
  a_uvblk_no_start: assert property (p_uvblk_no_start) else $error("started under block");

  // Zero block level leaves the block clear
  property p_zero_level_off;
    @(posedge clk_i) disable iff (rst_i)
      (tick_ff && under_block_level_ff == '0) |=> !uvblk_ff;
  endproperty
  a_zero_level_off: assert property (p_zero_level_off) else $error("block set at zero level");
endmodule

// ==== dv/svp_front.sv ====
`timescale 1ns/10ps
// Measurement front end and blocking matrix, refreshed once per period
module svp_front
  import svp_pkg::*;
#(
  parameter int PERIOD = 20
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic        [15:0]              amp_i,
  input  wire logic                            neg_i,
  input  wire logic                            blk_i,
  input  wire logic        [svp_pkg::PCT_W-1:0] lmin_i,
  input  wire logic        [svp_pkg::PCT_W-1:0] aux_i,
  output logic signed      [svp_pkg::PH_W-1:0] ph_re_o [3],
  output logic signed      [svp_pkg::PH_W-1:0] ph_im_o [3],
  output logic             [svp_pkg::PCT_W-1:0] aux_o,
  output logic             [svp_pkg::PCT_W-1:0] lmin_o,
  output logic                                 block_o
);
  logic        [31:0]     cnt_ff;
  logic signed [PH_W-1:0] half_w;
  logic signed [PH_W-1:0] quad_w;
  // Phases two and three at -120/+120 degrees, swapped for negative order
  assign half_w = -$signed({1'b0, amp_i[15:1]});
  assign quad_w = $signed(16'((32'(amp_i) * 32'd28378) >> 15));
  // All channels and the block line move only on the refresh edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      ph_re_o <= '{default: '0};
      ph_im_o <= '{default: '0};
      aux_o <= '0;
      lmin_o <= '0;
      block_o <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == PERIOD - 1) ? '0 : cnt_ff + 1;
      if (cnt_ff == PERIOD - 1) begin
        ph_re_o <= '{$signed(amp_i), half_w, half_w};
        ph_im_o <= '{'0, neg_i ? quad_w : -quad_w, neg_i ? -quad_w : quad_w};
        aux_o <= aux_i;
        lmin_o <= lmin_i;
        block_o <= blk_i;
      end
    end
  end
endmodule

// ==== dv/sequence_voltage_protection_test.sv ====
`timescale 1ns/10ps
module sequence_voltage_protection_test;
  import svp_pkg::*;
  typedef struct {bit rd; logic [31:0] exp; logic [31:0] msk;} svp_note_s;
  logic clk_i, rst_i, cyc, we, neg, blk, obs_en, ack_w, start_w, trip_w, blocked_w;
  logic [7:0] adr;
  logic [31:0] dat, rdat_w;
  logic [15:0] amp;
  logic [13:0] lmin, aux, aux_w, lmin_w;
  logic signed [15:0] re_w [3];
  logic signed [15:0] im_w [3];
  logic [2:0] last;
  logic block_w;
  svp_note_s q[$];
  int miscompares, samples_checked, seed;
  wire [2:0] outs_w = {blocked_w, trip_w, start_w};
  svp_front #(.PERIOD(20)) front (.clk_i(clk_i), .rst_i(rst_i), .amp_i(amp), .neg_i(neg), .blk_i(blk),
    .lmin_i(lmin), .aux_i(aux), .ph_re_o(re_w), .ph_im_o(im_w), .aux_o(aux_w), .lmin_o(lmin_w), .block_o(block_w));
  svp_stage #(.CYCLE_CNT(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .ph1_re_i(re_w[0]), .ph1_im_i(im_w[0]),
    .ph2_re_i(re_w[1]), .ph2_im_i(im_w[1]), .ph3_re_i(re_w[2]), .ph3_im_i(im_w[2]), .chan4_mag_i(aux_w),
    .line_min_i(lmin_w), .block_i(block_w), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat_w), .wb_ack_o(ack_w), .start_o(start_w),
    .trip_o(trip_w), .blocked_o(blocked_w));
  // Clock
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic mism(input string m);
    $display("MISMATCH %0t %s", $time, m);
    miscompares++;
  endtask
  task automatic chk(input bit rd, input logic [31:0] v);
    svp_note_s n;
    samples_checked++;
    if (q.size() == 0) begin
      mism("result without note");
    end else begin
      n = q.pop_front();
      if (n.rd !== rd || (v & n.msk) !== (n.exp & n.msk)) mism("value differs");
    end
  endtask
  // Result watcher: read data on ack, output vector on change
  always @(posedge clk_i) begin
    if (ack_w === 1'b1 && we === 1'b0) chk(1, rdat_w);
    if (obs_en && outs_w !== last) chk(0, {29'h0, outs_w});
    last = outs_w;
  end
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    n = 0;
    if (!w) q.push_back('{1'b1, d, m});
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_w !== 1'b1 && n < 50);
    if (n >= 50) mism("no ack");
    cyc <= 0;
  endtask
  task automatic wq;
    int n;
    n = 0;
    while (q.size() != 0 && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    if (q.size() != 0) mism("result missing");
    q.delete();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(0, a, e, m);
    wq();
  endtask
  task automatic expo(input logic [2:0] v, input logic [2:0] m);
    q.push_back('{1'b0, {29'h0, v}, {29'h0, m}});
    wq();
  endtask
  task automatic settle(input int t);
    repeat (t * 20) @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    mism("timeout");
    end_sim();
  end
  // Main sequence
  initial begin
    seed = 60717;
    {cyc, we, neg, blk, obs_en, adr, dat, amp, lmin, last} = '0;
    aux = 14'($random(seed));
    rst_i = 1;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    obs_en <= 1;
    rd(A_CTRL, CTRL_DEF, '1);
    rd(A_USET, 32'(USET_DEF), '1);
    rd(A_UNDER_BLOCK_LEVEL, 32'(UNDER_BLOCK_LEVEL_DEF), '1);
    rd(A_EXP, 32'(TDLY_DEF), '1);
    rd(A_PRI, 32'(USET_DEF) * VTSC_DEF / 100, '1);
    rd(8'h3c, 32'h0, '1);
    for (int f = 1; f < 4; f++) begin
      bus(1, A_CTRL, 32'h04 | (f << 3), 0);
      expo(3'b1 << (f - 1), f == 1 ? 3'h7 : 3'b1 << (f - 1));
    end
    bus(1, A_CTRL, 32'h0, 0);
    expo(3'b000, 3'h7);
    bus(1, A_USET, 32'd8000 + ($random(seed) & 32'h3ff), 0);
    bus(1, A_TDLY, 32'h0, 0);
    amp <= 16'd30000;
    aux <= 14'($random(seed));
    expo(3'b011, 3'h7);
    amp <= 0;
    expo(3'b000, 3'h7);
    bus(1, A_CTRL, 32'h1, 0);
    amp <= 16'd30000;
    settle(4);
    rd(A_STAT, 32'h0, 32'h3);
    neg <= 1;
    expo(3'b011, 3'h7);
    amp <= 0;
    expo(3'b000, 3'h7);
    neg <= 0;
    bus(1, A_CTRL, 32'h0, 0);
    bus(1, A_TDLY, 32'h3, 0);
    amp <= 16'd30000;
    q.push_back('{1'b0, 32'h1, 32'h7});
    expo(3'b011, 3'h7);
    amp <= 0;
    expo(3'b000, 3'h7);
    bus(1, A_TDLY, 32'h0, 0);
    bus(1, A_USET, 32'd10000, 0);
    amp <= 16'd10200; // Balanced amplitude A gives magnitude code near A
    expo(3'b011, 3'h7);
    amp <= 16'd9800;
    settle(4);
    rd(A_STAT, 32'h3, 32'h3);
    amp <= 16'd9600;
    expo(3'b000, 3'h7);
    obs_en <= 0;
    amp <= 16'd10400;
    bus(1, A_CTRL, 32'h2, 0);
    bus(1, A_UNDER_BLOCK_LEVEL, 32'h0, 0);
    settle(4);
    obs_en <= 1;
    amp <= 0;
    expo(3'b011, 3'h7);
    amp <= 16'd10200;
    settle(4);
    rd(A_STAT, 32'h3, 32'h3);
    amp <= 16'd10400;
    expo(3'b000, 3'h7);
    obs_en <= 0;
    bus(1, A_USET, 32'd9000, 0);
    bus(1, A_UNDER_BLOCK_LEVEL, 32'd500, 0);
    amp <= 0;
    settle(4);
    rd(A_STAT, 32'h20, 32'h22);
    amp <= 16'd30000;
    settle(4);
    rd(A_STAT, 32'h20, 32'h20);
    lmin <= 14'd9500;
    settle(4);
    rd(A_STAT, 32'h0, 32'h20);
    bus(1, A_CTRL, 32'h0, 0);
    bus(1, A_TDLY, 32'd50, 0);
    amp <= 0;
    blk <= 1;
    settle(4);
    obs_en <= 1;
    amp <= 16'd30000;
    expo(3'b100, 3'h7);
    amp <= 0;
    expo(3'b000, 3'h7);
    blk <= 0;
    settle(2);
    amp <= 16'd30000;
    expo(3'b001, 3'h7);
    obs_en <= 0;
    blk <= 1;
    settle(4);
    rd(A_STAT, 32'h0, 32'h1);
    settle(55);
    rd(A_STAT, 32'h0, 32'h3);
    end_sim();
  end
endmodule
